// >>> hw/guard_pkg.sv
// Package for the windowed guard timer: offsets, fields, reset values and state carriers.
// Assumes a single 10 MHz system clock and a plain strobe register port.
package guard_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_RELOAD = 4'h1;
   localparam logic [3:0] ADDR_FEED = 4'h2;
   localparam logic [3:0] ADDR_COUNT = 4'h3;
   localparam logic [3:0] ADDR_WARN = 4'h4;
   localparam logic [3:0] ADDR_WINDOW = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [3:0] ADDR_MASK = 4'h7;
   localparam logic [3:0] ADDR_CLKSEL = 4'h8;

   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam int MODE_EN_BIT = 0;
   localparam int MODE_RESET_BIT = 1;
   localparam int MODE_TOFLAG_BIT = 2;
   localparam int MODE_WARN_BIT = 3;
   localparam int ST_TIMEOUT_BIT = 0;
   localparam int ST_WARN_BIT = 1;
   localparam int ST_BADFEED_BIT = 2;
   localparam logic [7:0] FEED_FIRST = 8'haa;
   localparam logic [7:0] FEED_SECOND = 8'h55;
   localparam logic [23:0] RELOAD_MIN = 24'h0000ff;
   localparam logic [23:0] RELOAD_RESET = 24'h0000ff;
   localparam logic [23:0] WINDOW_RESET = 24'hffffff;
   localparam logic [9:0] WARN_RESET = 10'h000;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam int TICK_DIV_LAST = 7;
   localparam logic [2:0] TICK_DIV_LAST3 = 3'h7;
   localparam logic [2:0] STATUS_RESET = 3'h0;

   typedef enum logic [1:0] {
      FEED_IDLE = 2'b00,
      FEED_ARMED = 2'b01
   } feed_state_e;

   typedef struct packed {
      logic enable;
      logic reset_mode;
      logic warn_en;
   } mode_s;

   typedef struct packed {
      mode_s mode;
      logic [23:0] reload;
      logic [23:0] window;
      logic [9:0] warn_point;
      logic [23:0] count;
      logic [1:0] prescale;
      feed_state_e feed;
      logic [2:0] status;
      logic [2:0] mask;
      logic clk_sel;
      logic chip_reset;
      logic irq;
      logic [31:0] rdata;
   } guard_state_s;

   function automatic logic [23:0] clamp_reload(input logic [23:0] v);
      return (v < RELOAD_MIN) ? RELOAD_MIN : v;
   endfunction

endpackage

// >>> hw/guard_clock_tick.sv
// Edge detector that turns the chosen oscillator into one-cycle ticks.
// Assumes both oscillator inputs are slower than half the system clock.
`timescale 1ns/1ps
module guard_clock_tick
   import guard_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic sel_i,
   input wire logic osc_rc_i,
   input wire logic osc_lp_i,
   output logic tick_o
);
   logic [1:0] rc_sync_q;
   logic [1:0] lp_sync_q;
   logic last_q;
   logic now_w;

   // ----------------------------------------------------------------
   // Synchronisers and rising edge detect
   // ----------------------------------------------------------------
   assign now_w = sel_i ? lp_sync_q[1] : rc_sync_q[1];

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rc_sync_q <= 2'h0;
         lp_sync_q <= 2'h0;
         last_q <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         rc_sync_q <= {rc_sync_q[0], osc_rc_i};
         lp_sync_q <= {lp_sync_q[0], osc_lp_i};
         last_q <= now_w;
         tick_o <= now_w & ~last_q;
      end
   end
endmodule

// >>> hw/guard_reset_flag.sv
// Sticky flag that records a guard-timer reset; cleared only by power-on reset or software.
// Assumes a separate power-on reset that the chip reset does not drive.
`timescale 1ns/1ps
module guard_reset_flag
   import guard_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic por_b_i,
   input wire logic set_i,
   input wire logic clear_i,
   output logic flag_o
);
   // ----------------------------------------------------------------
   // Flag, set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge por_b_i) begin
      if (!por_b_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

// >>> hw/windowed_guard_timer.sv
// Windowed guard timer: 24-bit down counter, feed checking, window, warning and chip reset.
// Assumes rst_b_i is the chip reset, por_b_i the power-on reset, and a single 10 MHz clock.
//
// Operation
// - Reset chip when counter expires unfed
// - Window mode accepts feeds only at or below limit
// - Optional warning before time-out
// - Enable is sticky until reset; the code also clears it on any fault
// - Bad feed gives reset or interrupt
// - Flag shows last reset was guard
// - 24-bit counter through prescaler
// - Period 256x4 to 2^24x4 cycles
// - Software selects guard clock source
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module windowed_guard_timer
   import guard_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic por_b_i,
   input wire logic osc_rc_i,
   input wire logic osc_lp_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   output logic chip_reset_o,
   output logic reset_flag_o
);
   guard_state_s s_q;
   guard_state_s s_d;
   logic tick_w;
   logic flag_w;
   logic flag_clr_w;
   logic expire_w;
   logic feed_ok_w;
   logic feed_bad_w;
   logic fault_w;
   logic warn_w;
   logic [23:0] next_count_w;

   // ----------------------------------------------------------------
   // Clock tick and persistent flag
   // ----------------------------------------------------------------
   guard_clock_tick guard_clock_tick_i (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .sel_i(s_q.clk_sel),
      .osc_rc_i(osc_rc_i),
      .osc_lp_i(osc_lp_i),
      .tick_o(tick_w)
   );

   assign flag_clr_w = wr_i && (addr_i == ADDR_MODE) && wdata_i[MODE_TOFLAG_BIT];

   guard_reset_flag guard_reset_flag_i (
      .clk_sys_i(clk_sys_i),
      .por_b_i(por_b_i),
      .set_i(s_q.chip_reset),
      .clear_i(flag_clr_w),
      .flag_o(flag_w)
   );

   // ----------------------------------------------------------------
   // Feed and expiry decode
   // ----------------------------------------------------------------
   always_comb begin
      feed_ok_w = 1'b0;
      feed_bad_w = 1'b0;
      if (wr_i && s_q.mode.enable) begin
         if (addr_i == ADDR_FEED) begin
            if (s_q.feed == FEED_ARMED && wdata_i[7:0] == FEED_SECOND) begin
               if (s_q.count > s_q.window) begin
                  feed_bad_w = 1'b1;
               end else begin
                  feed_ok_w = 1'b1;
               end
            end else if (s_q.feed == FEED_ARMED || wdata_i[7:0] != FEED_FIRST) begin
               feed_bad_w = 1'b1;
            end
         end else if (s_q.feed == FEED_ARMED) begin
            feed_bad_w = 1'b1;
         end
      end
   end

   assign expire_w = s_q.mode.enable && tick_w && (s_q.prescale == PRESCALE_LAST) && (s_q.count == 24'h000000);
   assign fault_w = expire_w || feed_bad_w;
   assign next_count_w = s_q.count - 24'h000001;
   assign warn_w = s_q.mode.warn_en && s_q.mode.enable && (s_q.count == {14'h0000, s_q.warn_point})
                   && tick_w && (s_q.prescale == PRESCALE_LAST);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.chip_reset = 1'b0;
      s_d.rdata = 32'h00000000;
      // Feed sequence tracking
      case (s_q.feed)
         FEED_IDLE: begin
            if (wr_i && addr_i == ADDR_FEED && wdata_i[7:0] == FEED_FIRST && s_q.mode.enable) begin
               s_d.feed = FEED_ARMED;
            end
         end
         FEED_ARMED: begin
            if (wr_i) begin
               s_d.feed = FEED_IDLE;
            end
         end
         default: begin
            s_d.feed = FEED_IDLE;
         end
      endcase
      // Counter with divide-by-four prescaler
      if (s_q.mode.enable && tick_w) begin
         s_d.prescale = s_q.prescale + 2'h1;
         if (s_q.prescale == PRESCALE_LAST && s_q.count != 24'h000000) begin
            s_d.count = next_count_w;
         end
      end
      if (feed_ok_w) begin
         s_d.count = s_q.reload;
         s_d.prescale = 2'h0;
      end
      // Register writes
      if (wr_i) begin
         case (addr_i)
            ADDR_MODE: begin
               if (wdata_i[MODE_EN_BIT]) begin
                  s_d.mode.enable = 1'b1;
               end
               if (!s_q.mode.enable) begin
                  s_d.mode.reset_mode = wdata_i[MODE_RESET_BIT];
               end else if (wdata_i[MODE_RESET_BIT]) begin
                  s_d.mode.reset_mode = 1'b1;
               end
               s_d.mode.warn_en = wdata_i[MODE_WARN_BIT];
            end
            ADDR_RELOAD: begin
               s_d.reload = clamp_reload(wdata_i[23:0]);
               if (!s_q.mode.enable) begin
                  s_d.count = clamp_reload(wdata_i[23:0]);
               end
            end
            ADDR_WARN: s_d.warn_point = wdata_i[9:0];
            ADDR_WINDOW: s_d.window = wdata_i[23:0];
            ADDR_MASK: s_d.mask = wdata_i[2:0];
            ADDR_CLKSEL: begin
               if (!s_q.mode.enable) begin
                  s_d.clk_sel = wdata_i[0];
               end
            end
            default: begin
            end
         endcase
      end
      // Register reads; status read clears
      if (rd_i) begin
         case (addr_i)
            ADDR_MODE: s_d.rdata = {28'h0000000, s_q.mode.warn_en, flag_w, s_q.mode.reset_mode, s_q.mode.enable};
            ADDR_RELOAD: s_d.rdata = {8'h00, s_q.reload};
            ADDR_COUNT: s_d.rdata = {8'h00, s_q.count};
            ADDR_WARN: s_d.rdata = {22'h000000, s_q.warn_point};
            ADDR_WINDOW: s_d.rdata = {8'h00, s_q.window};
            ADDR_STATUS: begin
               s_d.rdata = {29'h00000000, s_q.status};
               s_d.status = STATUS_RESET;
            end
            ADDR_MASK: s_d.rdata = {29'h00000000, s_q.mask};
            ADDR_CLKSEL: s_d.rdata = {31'h00000000, s_q.clk_sel};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // Faults: status bits set after read-clear so set wins
      if (warn_w) begin
         s_d.status[ST_WARN_BIT] = 1'b1;
      end
      if (expire_w) begin
         s_d.status[ST_TIMEOUT_BIT] = 1'b1;
      end
      if (feed_bad_w) begin
         s_d.status[ST_BADFEED_BIT] = 1'b1;
      end
      if (fault_w) begin
         if (s_q.mode.reset_mode) begin
            s_d.chip_reset = 1'b1;
         end
         s_d.mode.enable = 1'b0;
      end
      s_d.irq = |(s_d.status & s_d.mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '{mode: '{enable: 1'b0, reset_mode: 1'b0, warn_en: 1'b0},
                  reload: RELOAD_RESET, window: WINDOW_RESET, warn_point: WARN_RESET,
                  count: RELOAD_RESET, prescale: 2'h0, feed: FEED_IDLE, status: STATUS_RESET,
                  mask: 3'h0, clk_sel: 1'b0, chip_reset: 1'b0, irq: 1'b0, rdata: 32'h00000000};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign irq_o = s_q.irq;
   assign chip_reset_o = s_q.chip_reset;
   assign reset_flag_o = flag_w;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_expiry_resets: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (expire_w && s_q.mode.reset_mode) |=> chip_reset_o)
      else $error("expiry did not reset chip");
   a_window_early: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (feed_ok_w) |-> (s_q.count <= s_q.window))
      else $error("feed accepted above window");
   a_enable_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.mode.enable && !fault_w) |=> s_q.mode.enable)
      else $error("enable dropped");
   a_badfeed_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      feed_bad_w |=> s_q.status[ST_BADFEED_BIT])
      else $error("bad feed not flagged");
   a_flag_follows: assert property (@(posedge clk_sys_i) disable iff (!por_b_i)
      chip_reset_o |=> reset_flag_o)
      else $error("reset flag not set");
   a_count_step: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (tick_w && s_q.mode.enable && s_q.prescale != PRESCALE_LAST && !wr_i) |=> $stable(s_q.count))
      else $error("counter stepped without prescale");
   a_reload_floor: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      s_q.reload >= RELOAD_MIN)
      else $error("reload below floor");
   a_clksel_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      s_q.mode.enable |=> (s_q.clk_sel == $past(s_q.clk_sel)))
      else $error("clock source changed while running");
   a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.status[ST_WARN_BIT] && s_q.mask[ST_WARN_BIT]) |-> irq_o)
      else $error("irq missing");
   a_early_feed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_FEED && s_q.feed == FEED_ARMED && s_q.count > s_q.window && s_q.mode.enable)
      |-> feed_bad_w)
      else $error("early feed not faulted");

   // ----------------------------------------------------------------
   // Checks: faults and enable
   // ----------------------------------------------------------------
   a_reset_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      chip_reset_o |=> !chip_reset_o)
      else $error("chip reset longer than one cycle");
   a_reset_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      chip_reset_o |-> $past(fault_w))
      else $error("chip reset without fault");
   a_timeout_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      expire_w |=> s_q.status[ST_TIMEOUT_BIT])
      else $error("expiry not flagged");
   a_irq_mode_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (fault_w && !s_q.mode.reset_mode) |=> !chip_reset_o)
      else $error("chip reset in interrupt mode");
   a_fault_disables: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      fault_w |=> !s_q.mode.enable)
      else $error("fault left timer enabled");
   a_enable_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_MODE && wdata_i[MODE_EN_BIT] && !fault_w) |=> s_q.mode.enable)
      else $error("enable write lost");
   a_reset_mode_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.mode.enable && s_q.mode.reset_mode) |=> s_q.mode.reset_mode)
      else $error("reset mode dropped while running");

   // ----------------------------------------------------------------
   // Checks: counter
   // ----------------------------------------------------------------
   a_disabled_still: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (!s_q.mode.enable && !wr_i) |=> ($stable(s_q.count) && $stable(s_q.prescale)))
      else $error("counter moved while disabled");
   a_count_dec: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.mode.enable && tick_w && s_q.prescale == PRESCALE_LAST && s_q.count != 24'h000000 && !wr_i)
      |=> (s_q.count == $past(s_q.count) - 24'h000001))
      else $error("counter did not step down");
   a_prescale_step: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.mode.enable && tick_w && !wr_i) |=> (s_q.prescale == $past(s_q.prescale) + 2'h1))
      else $error("prescaler did not step");
   a_count_zero_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.mode.enable && s_q.count == 24'h000000 && !wr_i) |=> (s_q.count == 24'h000000))
      else $error("counter wrapped below zero");
   a_reload_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_RELOAD && wdata_i[23:0] >= RELOAD_MIN) |=> (s_q.reload == $past(wdata_i[23:0])))
      else $error("reload write lost");
   a_count_read: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (rd_i && addr_i == ADDR_COUNT) |=> (rdata_o == {8'h00, $past(s_q.count)}))
      else $error("count read wrong");

   // ----------------------------------------------------------------
   // Checks: feed sequence
   // ----------------------------------------------------------------
   a_feed_reload: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      feed_ok_w |=> (s_q.count == $past(s_q.reload) && s_q.prescale == 2'h0))
      else $error("feed did not reload");
   a_late_feed_ok: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_FEED && s_q.feed == FEED_ARMED && wdata_i[7:0] == FEED_SECOND
       && s_q.mode.enable && s_q.count <= s_q.window) |-> feed_ok_w)
      else $error("feed inside window refused");
   a_arm_step: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_FEED && wdata_i[7:0] == FEED_FIRST && s_q.mode.enable && s_q.feed == FEED_IDLE)
      |=> (s_q.feed == FEED_ARMED))
      else $error("first feed word not taken");
   a_arm_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.feed == FEED_ARMED && wr_i) |=> (s_q.feed == FEED_IDLE))
      else $error("feed sequence stuck");
   a_stray_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.feed == FEED_ARMED && wr_i && addr_i != ADDR_FEED && s_q.mode.enable) |-> feed_bad_w)
      else $error("write inside feed not faulted");
   a_bad_feed_second: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_FEED && s_q.feed == FEED_ARMED && wdata_i[7:0] != FEED_SECOND && s_q.mode.enable)
      |-> feed_bad_w)
      else $error("wrong second feed word not faulted");
   a_bad_feed_first: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_FEED && s_q.feed == FEED_IDLE && wdata_i[7:0] != FEED_FIRST && s_q.mode.enable)
      |-> feed_bad_w)
      else $error("wrong first feed word not faulted");

   // ----------------------------------------------------------------
   // Checks: flags and register port
   // ----------------------------------------------------------------
   a_warn_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      warn_w |=> s_q.status[ST_WARN_BIT])
      else $error("warning not flagged");
   a_warn_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (!s_q.status[ST_WARN_BIT] && !warn_w) |=> !s_q.status[ST_WARN_BIT])
      else $error("warning flagged without event");
   a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (s_q.status[ST_BADFEED_BIT] && !(rd_i && addr_i == ADDR_STATUS)) |=> s_q.status[ST_BADFEED_BIT])
      else $error("bad feed flag lost");
   a_status_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (rd_i && addr_i == ADDR_STATUS && !fault_w && !warn_w) |=> (s_q.status == STATUS_RESET))
      else $error("status read did not clear");
   a_flag_read: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (rd_i && addr_i == ADDR_MODE) |=> (rdata_o[MODE_TOFLAG_BIT] == $past(reset_flag_o)))
      else $error("reset flag read wrong");
   a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!por_b_i)
      (flag_clr_w && !chip_reset_o) |=> !reset_flag_o)
      else $error("reset flag not cleared");
   a_flag_hold: assert property (@(posedge clk_sys_i) disable iff (!por_b_i)
      (reset_flag_o && !flag_clr_w) |=> reset_flag_o)
      else $error("reset flag lost");
   a_clksel_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_CLKSEL && !s_q.mode.enable) |=> (s_q.clk_sel == $past(wdata_i[0])))
      else $error("clock source write lost");
endmodule

// >>> tb/windowed_guard_timer_bench.sv
// Bench for the windowed guard timer: register port, feeds, faults, warning, clock choice.
// Assumes the design package; chip reset looped back into rst_b_i for two cycles.
`timescale 1ns/1ps
module windowed_guard_timer_bench
   import guard_pkg::*;
();
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} note_s;
   note_s notes[$];
   logic clk_sys = 0, rst_q = 0, por_q = 0, rc = 0, lp = 0, lp_run = 1;
   logic wr = 0, rd = 0, rd_seen = 0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] hold = 2'h0;
   logic [2:0] lpc = 3'h0;
   logic irq, chip_rst, flag;
   int failures = 0, compares = 0, resets = 0, n, cyc = 0;
   localparam int T_OUT = (int'(RELOAD_RESET) + 1) * 4 * 4;
   wire rst_b = rst_q & ~(|hold);

   always #50 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // Oscillators and reset loop
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      rc <= cyc[1];
      hold <= {hold[0], chip_rst};
      if (chip_rst === 1'b1) resets <= resets + 1;
      if (lp_run) begin
         lpc <= (lpc == 3'h5) ? 3'h0 : lpc + 3'h1;
         lp <= (lpc < 3'h3);
      end
   end

   windowed_guard_timer windowed_guard_timer_i (
      .clk_sys_i(clk_sys), .rst_b_i(rst_b), .por_b_i(por_q), .osc_rc_i(rc), .osc_lp_i(lp),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .irq_o(irq), .chip_reset_o(chip_rst), .reset_flag_o(flag));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(string nm, logic [31:0] ex, logic [31:0] got);
      compares++;
      if (got !== ex) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic take();
      note_s x;
      x = notes.pop_front();
      check(x.nm, x.ex & x.mk, rdata & x.mk);
   endtask

   always @(posedge clk_sys) begin
      rd_seen <= rd;
      if (rd_seen) take();
   end

   task automatic wr_reg(logic [3:0] a, logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(string nm, logic [3:0] a, logic [31:0] ex, logic [31:0] mk);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      notes.push_back('{nm, ex, mk});
      @(posedge clk_sys);
      rd <= 1'b0;
   endtask

   task automatic feed();
      wr_reg(ADDR_FEED, {24'h0, FEED_FIRST});
      wr_reg(ADDR_FEED, {24'h0, FEED_SECOND});
   endtask

   task automatic do_reset(logic p);
      @(posedge clk_sys);
      rst_q <= 1'b0;
      por_q <= ~p;
      repeat (4) @(posedge clk_sys);
      rst_q <= 1'b1;
      por_q <= 1'b1;
   endtask

   task automatic arm(logic [31:0] w, logic [31:0] m, logic [31:0] md, logic [31:0] cs);
      do_reset(1'b0);
      wr_reg(ADDR_WINDOW, w);
      wr_reg(ADDR_WARN, 32'hf8);
      wr_reg(ADDR_CLKSEL, cs);
      wr_reg(ADDR_MASK, m);
      wr_reg(ADDR_MODE, md);
   endtask

   task automatic wait_irq(logic v, int lim);
      n = 0;
      while (irq !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check("irq_o", {31'h0, v}, {31'h0, irq});
   endtask

   task automatic end_of_test();
      if (failures == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] v;
      v = $urandom(32'h8395908c);
      do_reset(1'b1);
      rd_reg("mode", ADDR_MODE, 32'h0, 32'hf);
      rd_reg("reload", ADDR_RELOAD, {8'h0, RELOAD_RESET}, 32'hffffff);
      rd_reg("window", ADDR_WINDOW, {8'h0, WINDOW_RESET}, 32'hffffff);
      rd_reg("count", ADDR_COUNT, 32'hff, 32'hffffff);
      rd_reg("warn", ADDR_WARN, 32'h0, 32'h3ff);
      rd_reg("status", ADDR_STATUS, 32'h0, 32'h7);
      rd_reg("mask", ADDR_MASK, 32'h0, 32'h7);
      rd_reg("clksel", ADDR_CLKSEL, 32'h0, 32'h1);
      rd_reg("unmapped", 4'hf, 32'h0, 32'hffffffff);
      wr_reg(ADDR_RELOAD, $urandom % 32'hff);
      rd_reg("reload", ADDR_RELOAD, 32'hff, 32'hffffff);
      v = 32'h100 + ($urandom % 32'hfff00);
      wr_reg(ADDR_RELOAD, v);
      rd_reg("reload", ADDR_RELOAD, v, 32'hffffff);
      wr_reg(ADDR_RELOAD, 32'hff);
      wr_reg(ADDR_MODE, 32'h3);
      wr_reg(ADDR_MODE, 32'h0);
      rd_reg("enable", ADDR_MODE, 32'h1, 32'h1);
      repeat (3) begin
         repeat (2500) @(posedge clk_sys);
         feed();
      end
      check("resets", 32'h0, resets);
      n = 0;
      while (resets == 0 && n < 6000) begin
         @(posedge clk_sys);
         n++;
      end
      check("expiry", 32'h1, {31'h0, (n >= T_OUT - 24 && n <= T_OUT + 24)});
      repeat (5) @(posedge clk_sys);
      #1;
      check("reset_flag_o", 32'h1, {31'h0, flag});
      rd_reg("flag", ADDR_MODE, 32'h4, 32'h5);
      wr_reg(ADDR_MODE, 32'h4);
      @(posedge clk_sys);
      #1;
      check("reset_flag_o", 32'h0, {31'h0, flag});
      wr_reg(ADDR_MASK, 32'h4);
      wr_reg(ADDR_MODE, 32'h1);
      wr_reg(ADDR_FEED, {24'h0, FEED_FIRST});
      wr_reg(ADDR_FEED, $urandom % 32'h55);
      wait_irq(1'b1, 8);
      check("resets", 32'h1, resets);
      rd_reg("enable", ADDR_MODE, 32'h0, 32'h1);
      rd_reg("status", ADDR_STATUS, 32'h4, 32'h4);
      rd_reg("status", ADDR_STATUS, 32'h0, 32'h4);
      wait_irq(1'b0, 4);
      arm(32'hf0, 32'h4, 32'h1, 32'h0);
      feed();
      wait_irq(1'b1, 8);
      arm(32'hf0, 32'h4, 32'h1, 32'h0);
      repeat (400) @(posedge clk_sys);
      feed();
      repeat (8) @(posedge clk_sys);
      #1;
      check("irq_o", 32'h0, {31'h0, irq});
      rd_reg("count", ADDR_COUNT, 32'hf0, 32'hfffff0);
      arm(WINDOW_RESET, 32'h2, 32'h9, 32'h0);
      repeat (60) @(posedge clk_sys);
      #1;
      check("irq_o", 32'h0, {31'h0, irq});
      wait_irq(1'b1, 200);
      rd_reg("status", ADDR_STATUS, 32'h2, 32'h2);
      lp_run <= 1'b0;
      arm(WINDOW_RESET, 32'h0, 32'h1, 32'h1);
      rd_reg("clksel", ADDR_CLKSEL, 32'h1, 32'h1);
      repeat (400) @(posedge clk_sys);
      rd_reg("count", ADDR_COUNT, 32'hff, 32'hffffff);
      lp_run <= 1'b1;
      repeat (1200) @(posedge clk_sys);
      rd_reg("count", ADDR_COUNT, 32'hcc, 32'hfffffc);
      repeat (4) @(posedge clk_sys);
      end_of_test();
   end
endmodule
